// File: design/dither_and_timestamp_control.sv
// Dither and sample-marker control registers with APB access and marked sample output.
// Behaviour
// - Dither register reset is 0x01, then takes a one-time factory fuse value unless software writes it first.
// - Dither bit 0 turns sample dither on; resets to one.
// - Dither bit 1 picks large dither when set, small dither when clear.
// - Dither bit 2 sends rounding error to offset and half-rate spur when set.
// - Offset-targeted rounding in single-channel mode also raises the quarter-rate spur.
// - Sample control bit 0, reset zero, puts the marker on every sample LSB.
// - Marker path latency equals sample path latency end to end.
// - With marker on, only upper seven sample bits carry conversion data.
// - Alignment sequence always reports zero control bits per sample.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "dtc_defines.svh"
module dither_and_timestamp_control (
  // Clock and reset
  input  wire logic                CLK,
  input  wire logic                ARST_N,
  // APB slave
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire dtc_pkg::apb_addr_t  PADDR,
  input  wire dtc_pkg::apb_data_t  PWDATA,
  input  wire dtc_pkg::apb_strb_t  PSTRB,
  output dtc_pkg::apb_data_t       PRDATA,
  output logic                     PREADY,
  output logic                     PSLVERR,
  // Factory fuse storage
  input  wire logic                FUSE_VALID,
  input  wire dtc_pkg::reg8_t      FUSE_DATA,
  // Converter mode
  input  wire logic                SINGLE_CHANNEL,
  // Dither controls to the converter core
  output logic                     DITHER_ON,
  output logic                     DITHER_LARGE,
  output logic                     ROUND_TO_OFFSET,
  output logic                     QUARTER_SPUR_RAISE,
  // Sample path
  input  wire logic                SAMPLE_VALID,
  input  wire dtc_pkg::reg8_t      SAMPLE_IN,
  input  wire logic                TIMESTAMP_IN,
  output logic                     SAMPLE_OUT_VALID,
  output dtc_pkg::reg8_t           SAMPLE_OUT,
  // Link framing information
  output logic                     MARKER_ON_LSB,
  output logic [1:0]               ILA_CTRL_BITS
);
  import dtc_pkg::*;

  reg8_t       dith_r;
  reg8_t       lsb_r;
  apb_data_t   prdata_r;
  fuse_state_t fuse_st_r;
  logic        setup;
  logic        access;
  logic        hit_dith;
  logic        hit_lsb;
  logic        wr_dith;
  logic        wr_lsb;
  logic        ts_s1_r;
  logic        ts_s2_r;
  logic        ts_s3_r;
  logic        ts_filt_r;
  logic        spur_r;
  logic        out_valid_r;
  reg8_t       out_r;
  logic [1:0]  ila_r;
  logic [`DTC_SAMPLE_W:0] pipe_in;
  logic [`DTC_SAMPLE_W:0] pipe_out;

  // APB decode. The slave answers with no wait states.
  assign setup    = PSEL && !PENABLE;
  assign access   = PSEL && PENABLE;
  assign hit_dith = (PADDR == `DTC_DITH_ADDR);
  assign hit_lsb  = (PADDR == `DTC_LSB_ADDR);
  assign wr_dith  = access && PWRITE && hit_dith && PSTRB[0];
  assign wr_lsb   = access && PWRITE && hit_lsb && PSTRB[0];
  assign PREADY   = 1'b1;
  assign PSLVERR  = access && !(hit_dith || hit_lsb);
  assign PRDATA   = prdata_r;

  // Read data is sampled in the setup phase so that it leaves a flip-flop.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prdata_r <= '0;
    end else if (setup && !PWRITE) begin
      if (PADDR == `DTC_DITH_ADDR) begin
        prdata_r <= {`DTC_PAD_ZERO, dith_r};
      end else if (PADDR == `DTC_LSB_ADDR) begin
        prdata_r <= {`DTC_PAD_ZERO, lsb_r};
      end else begin
        prdata_r <= '0;
      end
    end
  end

  // Fuse loader: one load per reset, a software write in the same cycle wins.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fuse_st_r <= FUSE_WAIT;
    end else begin
      case (fuse_st_r)
        FUSE_WAIT: begin
          if (FUSE_VALID || wr_dith) begin
            fuse_st_r <= FUSE_LOADED;
          end
        end
        FUSE_LOADED: begin
          fuse_st_r <= FUSE_LOADED;
        end
        default: begin
          fuse_st_r <= FUSE_WAIT;
        end
      endcase
    end
  end

  // Dither register.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dith_r <= `DTC_DITH_RST;
    end else if (wr_dith) begin
      dith_r <= PWDATA[`DTC_REG_W-1:0];
    end else if (fuse_st_r == FUSE_WAIT && FUSE_VALID) begin
      dith_r <= FUSE_DATA;
    end
  end

  // Sample control register.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lsb_r <= `DTC_LSB_RST;
    end else if (wr_lsb) begin
      lsb_r <= PWDATA[`DTC_REG_W-1:0];
    end
  end

  assign DITHER_ON       = dith_r[`DTC_DITH_ON_BIT];
  assign DITHER_LARGE    = dith_r[`DTC_DITH_SIZE_BIT];
  assign ROUND_TO_OFFSET = dith_r[`DTC_DITH_ERR_BIT];
  assign MARKER_ON_LSB   = lsb_r[`DTC_MARK_BIT];
  assign QUARTER_SPUR_RAISE = spur_r;

  // Mode input comes from on-chip configuration on this clock, so no synchroniser.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      spur_r <= 1'b0;
    end else begin
      spur_r <= dith_r[`DTC_DITH_ERR_BIT] && SINGLE_CHANNEL;
    end
  end

  // The marker pin is asynchronous; a change is accepted once two stages agree.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ts_s1_r   <= 1'b0;
      ts_s2_r   <= 1'b0;
      ts_s3_r   <= 1'b0;
      ts_filt_r <= 1'b0;
    end else begin
      ts_s1_r <= TIMESTAMP_IN;
      ts_s2_r <= ts_s1_r;
      ts_s3_r <= ts_s2_r;
      if (ts_s2_r == ts_s3_r) begin
        ts_filt_r <= ts_s3_r;
      end
    end
  end

  assign pipe_in = {SAMPLE_VALID, SAMPLE_IN};

  marker_delay #(
    .WIDTH (`DTC_SAMPLE_W + 1),
    .DEPTH (`DTC_PIPE_DEPTH)
  ) u_sample_delay (
    .clk    (CLK),
    .arst_n (ARST_N),
    .din    (pipe_in),
    .dout   (pipe_out)
  );

  // Output stage. Switching the marker mid-stream takes effect on the next word.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      out_valid_r <= 1'b0;
      out_r       <= '0;
    end else begin
      out_valid_r <= pipe_out[`DTC_SAMPLE_W];
      if (lsb_r[`DTC_MARK_BIT]) begin
        out_r <= {pipe_out[`DTC_SAMPLE_W-1:1], ts_filt_r};
      end else begin
        out_r <= pipe_out[`DTC_SAMPLE_W-1:0];
      end
    end
  end

  assign SAMPLE_OUT_VALID = out_valid_r;
  assign SAMPLE_OUT       = out_r;

  // The marker bit is never advertised, so the link sees no control bits.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ila_r <= `DTC_ILA_CS;
    end else begin
      ila_r <= `DTC_ILA_CS;
    end
  end

  assign ILA_CTRL_BITS = ila_r;

  property p_fuse_load;
    @(posedge CLK) disable iff (!ARST_N)
    (fuse_st_r == FUSE_WAIT && FUSE_VALID && !wr_dith) |=> (dith_r == $past(FUSE_DATA))
      ##1 (fuse_st_r == FUSE_LOADED);
  endproperty
  a_fuse_load: assert property (p_fuse_load)
    else $error("Fuse value not loaded into dither register.");

  property p_dither_on;
    @(posedge CLK) disable iff (!ARST_N)
    wr_dith |=> (DITHER_ON == $past(PWDATA[`DTC_DITH_ON_BIT]));
  endproperty
  a_dither_on: assert property (p_dither_on)
    else $error("Dither enable does not follow write.");

  property p_dither_size_read;
    @(posedge CLK) disable iff (!ARST_N)
    (setup && !PWRITE && hit_dith) |=> (PRDATA[`DTC_DITH_SIZE_BIT] == DITHER_LARGE);
  endproperty
  a_dither_size_read: assert property (p_dither_size_read)
    else $error("Dither size readback mismatch.");

  property p_round_target;
    @(posedge CLK) disable iff (!ARST_N)
    wr_dith ##1 !wr_dith |-> (ROUND_TO_OFFSET == $past(PWDATA[`DTC_DITH_ERR_BIT], 2));
  endproperty
  a_round_target: assert property (p_round_target)
    else $error("Rounding target does not follow write.");

  property p_quarter_spur;
    @(posedge CLK) disable iff (!ARST_N)
    ##1 (QUARTER_SPUR_RAISE == ($past(ROUND_TO_OFFSET) && $past(SINGLE_CHANNEL)));
  endproperty
  a_quarter_spur: assert property (p_quarter_spur)
    else $error("Quarter-rate spur flag wrong.");

  property p_marker_off_lsb;
    @(posedge CLK) disable iff (!ARST_N)
    (SAMPLE_OUT_VALID && !$past(MARKER_ON_LSB)) |-> (SAMPLE_OUT[0] == $past(SAMPLE_IN[0], 5));
  endproperty
  a_marker_off_lsb: assert property (p_marker_off_lsb)
    else $error("LSB altered while marker is off.");

  property p_marker_latency;
    @(posedge CLK) disable iff (!ARST_N)
    (SAMPLE_OUT_VALID && $past(MARKER_ON_LSB)
      && $past(TIMESTAMP_IN, 3) == $past(TIMESTAMP_IN, 4)
      && $past(TIMESTAMP_IN, 4) == $past(TIMESTAMP_IN, 5)
      && $past(TIMESTAMP_IN, 5) == $past(TIMESTAMP_IN, 6)
      && $past(TIMESTAMP_IN, 6) == $past(TIMESTAMP_IN, 7))
      |-> (SAMPLE_OUT[0] == $past(TIMESTAMP_IN, 5));
  endproperty
  a_marker_latency: assert property (p_marker_latency)
    else $error("Marker not aligned with its sample.");

  property p_upper_bits;
    @(posedge CLK) disable iff (!ARST_N)
    SAMPLE_OUT_VALID |-> (SAMPLE_OUT[7:1] == $past(SAMPLE_IN[7:1], 5))
      && $past(SAMPLE_VALID, 5);
  endproperty
  a_upper_bits: assert property (p_upper_bits)
    else $error("Upper sample bits or latency wrong.");

  property p_ila_zero;
    @(posedge CLK) disable iff (!ARST_N)
    $rose(MARKER_ON_LSB) |-> (ILA_CTRL_BITS == `DTC_ILA_CS) [*3];
  endproperty
  a_ila_zero: assert property (p_ila_zero)
    else $error("Alignment sequence reports control bits.");

  property p_reserved_kept;
    @(posedge CLK) disable iff (!ARST_N)
    wr_lsb |=> (lsb_r[`DTC_RSVD_HI:`DTC_LSB_RSVD_LO]
      == $past(PWDATA[`DTC_RSVD_HI:`DTC_LSB_RSVD_LO]));
  endproperty
  a_reserved_kept: assert property (p_reserved_kept)
    else $error("Reserved bits not stored.");

endmodule : dither_and_timestamp_control

// File: design/marker_delay.sv
// Fixed-depth delay line that keeps sample words in step with the synchronised marker.
`timescale 1ns/1ps
module marker_delay #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage_r [DEPTH];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage_r[i] <= '0;
      end
    end else begin
      stage_r[0] <= din;
      for (int i = 1; i < DEPTH; i++) begin
        stage_r[i] <= stage_r[i-1];
      end
    end
  end

  assign dout = stage_r[DEPTH-1];

endmodule : marker_delay

// File: include/dtc_defines.svh
// Offsets, field positions, reset values and latencies of the dither and timestamp registers.
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH

// Register indices as printed; byte address is four times the index.
`define DTC_DITH_IDX       10'h09D
`define DTC_LSB_IDX        10'h160
`define DTC_DITH_ADDR      {`DTC_DITH_IDX, 2'h0}
`define DTC_LSB_ADDR       {`DTC_LSB_IDX, 2'h0}
`define DTC_ALIGN_ZERO     2'h0

// Reset values.
`define DTC_DITH_RST       8'h01
`define DTC_LSB_RST        8'h00

// Field positions.
`define DTC_DITH_ON_BIT    0
`define DTC_DITH_SIZE_BIT  1
`define DTC_DITH_ERR_BIT   2
`define DTC_MARK_BIT       0
`define DTC_RSVD_HI        7
`define DTC_DITH_RSVD_LO   3
`define DTC_LSB_RSVD_LO    1

// Sample path geometry.
`define DTC_SAMPLE_W       8
`define DTC_PIPE_DEPTH     4
`define DTC_ILA_CS         2'h0
`define DTC_REG_W          8
`define DTC_PAD_W          24
`define DTC_PAD_ZERO       24'h000000

`endif

// File: include/dtc_pkg.sv
// Types shared by the dither and timestamp control design.
package dtc_pkg;

  typedef logic [7:0]  reg8_t;
  typedef logic [11:0] apb_addr_t;
  typedef logic [31:0] apb_data_t;
  typedef logic [3:0]  apb_strb_t;

  typedef enum logic {
    FUSE_WAIT,
    FUSE_LOADED
  } fuse_state_t;

endpackage : dtc_pkg

// File: testbench/tb.sv
// Self-checking bench for the dither and timestamp control block.
`timescale 1ns/1ps
`include "dtc_defines.svh"
module tb;
  import dtc_pkg::*;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  apb_addr_t   paddr = 12'h000;
  apb_data_t   pwdata = 32'h00000000;
  apb_data_t   prdata;
  logic        pready;
  logic        pslverr;
  logic        fuse_valid = 1'b0;
  reg8_t       fuse_data = 8'h00;
  logic        single_ch = 1'b0;
  logic        dith_on;
  logic        dith_large;
  logic        round_off;
  logic        quarter;
  logic        svalid = 1'b0;
  reg8_t       sin = 8'h00;
  logic        tstamp = 1'b1;
  logic        sout_valid;
  reg8_t       sout;
  logic        mark_on;
  logic [1:0]  ila_bits;
  int          err_count = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          i;

  dither_and_timestamp_control u_dither_and_timestamp_control (
    .CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .FUSE_VALID(fuse_valid), .FUSE_DATA(fuse_data),
    .SINGLE_CHANNEL(single_ch), .DITHER_ON(dith_on), .DITHER_LARGE(dith_large),
    .ROUND_TO_OFFSET(round_off), .QUARTER_SPUR_RAISE(quarter), .SAMPLE_VALID(svalid),
    .SAMPLE_IN(sin), .TIMESTAMP_IN(tstamp), .SAMPLE_OUT_VALID(sout_valid),
    .SAMPLE_OUT(sout), .MARKER_ON_LSB(mark_on), .ILA_CTRL_BITS(ila_bits));

  always #25 clk = ~clk;

  // A hang is cut short long after the sequence should have ended.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count = err_count + 1;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input apb_addr_t a, input apb_data_t wd,
                     output apb_data_t rd, output logic er);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input apb_addr_t a, input apb_data_t d);
    apb_data_t rd;
    logic      er;
    apb(1'b1, a, d, rd, er);
  endtask : wr

  task automatic rd_chk(input apb_addr_t a, input apb_data_t exp, input logic exp_err);
    apb_data_t rd;
    logic      er;
    apb(1'b0, a, 32'h00000000, rd, er);
    chk(rd, exp);
    chk(er, exp_err);
  endtask : rd_chk

  // One word in, checked five cycles later and not a cycle earlier.
  task automatic smp(input reg8_t x, input reg8_t exp);
    svalid <= 1'b1;
    sin <= x;
    @(posedge clk);
    svalid <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(sout_valid, 1'b0);
    @(negedge clk);
    chk(sout_valid, 1'b1);
    chk(sout, exp);
    @(posedge clk);
  endtask : smp

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk(dith_on, 1'b1);
    rd_chk(`DTC_DITH_ADDR, 32'h00000001, 1'b0);
    rd_chk(`DTC_LSB_ADDR, 32'h00000000, 1'b0);
    chk(ila_bits, 2'h0);
    fuse_data <= 8'h06;
    fuse_valid <= 1'b1;
    @(posedge clk);
    fuse_valid <= 1'b0;
    @(negedge clk);
    chk({round_off, dith_large, dith_on}, 3'h6);
    @(posedge clk);
    // Only the first fuse pulse after reset may load.
    fuse_data <= 8'h01;
    fuse_valid <= 1'b1;
    @(posedge clk);
    fuse_valid <= 1'b0;
    rd_chk(`DTC_DITH_ADDR, 32'h00000006, 1'b0);
    for (i = 0; i < 8; i++) begin
      wr(`DTC_DITH_ADDR, {24'h000000, 5'h15, i[2:0]});
      chk({round_off, dith_large, dith_on}, i[2:0]);
      rd_chk(`DTC_DITH_ADDR, {24'h000000, 5'h15, i[2:0]}, 1'b0);
    end
    single_ch <= 1'b1;
    @(negedge clk);
    chk(quarter, 1'b0);
    @(negedge clk);
    chk(quarter, 1'b1);
    // The next request must start on a rising edge, not the falling one.
    @(posedge clk);
    wr(`DTC_DITH_ADDR, 32'h00000001);
    // The spur flag is registered, so it settles one edge after the write lands.
    @(negedge clk);
    chk(quarter, 1'b0);
    @(posedge clk);
    wr(12'h278, 32'h000000FF);
    rd_chk(12'h278, 32'h00000000, 1'b1);
    rd_chk(`DTC_DITH_ADDR, 32'h00000001, 1'b0);
    smp(8'hA4, 8'hA4);
    wr(`DTC_LSB_ADDR, 32'h00000081);
    chk(mark_on, 1'b1);
    rd_chk(`DTC_LSB_ADDR, 32'h00000081, 1'b0);
    chk(ila_bits, 2'h0);
    smp(8'hA4, 8'hA5);
    tstamp <= 1'b0;
    repeat (8) @(posedge clk);
    smp(8'h5B, 8'h5A);
    wr(`DTC_LSB_ADDR, 32'h000000FE);
    chk(mark_on, 1'b0);
    smp(8'h5B, 8'h5B);
    final_report();
  end
endmodule : tb
